// >>> hdl/bbx_pkg.sv
package bbx_pkg;
   // widths of the program counter, data address and bank select
   localparam int PC_W = 21;
   localparam int BANK_W = 4;
   localparam int FADDR_W = 8;
   localparam int DADDR_W = BANK_W + FADDR_W;

   // opcode fields
   localparam logic [4:0] OP_REL_JUMP = 5'h1A;
   localparam logic [3:0] OP_BIT_SET = 4'h8;
   localparam logic [3:0] OP_SKIP_CLR = 4'hB;
   localparam logic [3:0] OP_SKIP_SET = 4'hA;

   // field positions inside the instruction word
   localparam int JMP_OFS_MSB = 10;
   localparam int BIT_IDX_LSB = 9;
   localparam int ACC_SEL_POS = 8;

   // phases of one instruction cycle
   localparam logic [1:0] PH_DECODE = 2'h0;
   localparam logic [1:0] PH_READ = 2'h1;
   localparam logic [1:0] PH_PROC = 2'h2;
   localparam logic [1:0] PH_WRITE = 2'h3;

   // fixed access bank: low half in bank 0, high half in the top bank
   localparam logic [FADDR_W-1:0] ACCESS_SPLIT = 8'h80;
   localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;

   // reset values
   localparam logic [15:0] RST_INSTR = 16'h0000;
   localparam logic [1:0] RST_PHASE = 2'h0;

   typedef enum logic [1:0] {ST_EXEC, ST_IDLE, ST_IDLE2} bbx_state_t;
endpackage

// >>> hdl/bbx_bit_if.sv
`timescale 1ns/100ps
interface bbx_bit_if;
   logic [7:0] data;
   logic [2:0] bit_idx;
   logic skip_on_set;
   logic [7:0] set_data;
   logic skip;

   modport core (output data, output bit_idx, output skip_on_set,
                 input set_data, input skip);
   modport alu (input data, input bit_idx, input skip_on_set,
                output set_data, output skip);
endinterface

// >>> hdl/bbx_bit_alu.sv
`timescale 1ns/100ps
module bbx_bit_alu
   import bbx_pkg::*;
(
   bbx_bit_if.alu bus
);
   wire [7:0] onehot;
   wire bit_val;

   // one-hot mask of the selected bit
   assign onehot = 8'h01 << bus.bit_idx;
   // other bits pass through untouched
   assign bus.set_data = bus.data | onehot; // RQ6
   assign bit_val = |(bus.data & onehot);
   // skip when the bit matches the polarity the opcode asks for
   assign bus.skip = bus.skip_on_set ? bit_val : ~bit_val; // RQ8 RQ9
endmodule

// >>> hdl/bbx_exec.sv
`timescale 1ns/100ps
// Overview of operation
// RQ1: top five bits 11010 decode relative jump
// RQ2: signed 11-bit offset, doubled before adding
// RQ3: target is incremented PC plus doubled offset
// RQ4: jump takes two cycles, PC written last
// RQ5: top nibble 1000 decodes bit set
// RQ6: bit set forces one selected bit only
// RQ7: selector 0 access bank, 1 bank register
// RQ8: nibble 1011 skips when bit clear
// RQ9: nibble 1010 skips when bit set
// RQ10: taken skip discards prefetch, adds idle cycle
// RQ11: skipping two-word instruction costs three cycles
// RQ12: bit set reads phase two, writes four
module bbx_exec
   import bbx_pkg::*;
#(
   parameter int PCW = PC_W
)
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [15:0] i_instr,
   input wire logic i_next_two_word,
   input wire logic [PCW-1:0] i_pc,
   input wire logic [BANK_W-1:0] i_bank_sel,
   input wire logic [7:0] i_mem_rdata,
   output logic [1:0] o_phase,
   output logic o_instr_take,
   output logic o_flush,
   output logic o_pc_load,
   output logic [PCW-1:0] o_pc_target,
   output logic o_mem_rd,
   output logic o_mem_wr,
   output logic [DADDR_W-1:0] o_mem_addr,
   output logic [7:0] o_mem_wdata
);
   bbx_state_t state_r, state_nxt;
   logic [1:0] phase_r;
   logic [15:0] instr_r;
   logic [7:0] data_r;
   logic [PCW-1:0] target_r;
   logic pc_load_r;
   logic rd_r;
   logic wr_r;
   logic [DADDR_W-1:0] addr_r;
   logic [7:0] wdata_r;
   logic two_word_r, two_word_nxt;

   bbx_bit_if bit_bus ();

   bbx_bit_alu u_alu (
      .bus (bit_bus.alu)
   );

   // decode of the word now executing
   wire exec = (state_r == ST_EXEC);
   wire is_jump = (instr_r[15:11] == OP_REL_JUMP); // RQ1
   wire is_bset = (instr_r[15:12] == OP_BIT_SET); // RQ5
   wire is_skc = (instr_r[15:12] == OP_SKIP_CLR); // RQ8
   wire is_sks = (instr_r[15:12] == OP_SKIP_SET); // RQ9
   wire is_skip_op = is_skc | is_sks;
   wire uses_file = is_bset | is_skip_op;
   wire [2:0] bit_idx = instr_r[BIT_IDX_LSB+2:BIT_IDX_LSB];
   wire acc_sel = instr_r[ACC_SEL_POS];
   wire [FADDR_W-1:0] faddr = instr_r[FADDR_W-1:0];

   // bank choice; the bank register is ignored for access-bank operands
   wire [BANK_W-1:0] acc_bank = (faddr < ACCESS_SPLIT) ? ACCESS_LO_BANK
                                                       : ACCESS_HI_BANK;
   wire [BANK_W-1:0] bank = acc_sel ? i_bank_sel : acc_bank; // RQ7

   // offset sign-extended and doubled; i_pc already points past this word
   wire [PCW-1:0] jump_ofs = {{(PCW-JMP_OFS_MSB-2){instr_r[JMP_OFS_MSB]}},
                              instr_r[JMP_OFS_MSB:0], 1'b0}; // RQ2
   wire [PCW-1:0] jump_dest = i_pc + jump_ofs; // RQ3

   // skip outcome is known once the read phase data has been sampled
   wire skip_taken = exec & is_skip_op & bit_bus.skip;
   wire cycle_end = (phase_r == PH_WRITE);

   // phase-qualified strobes for the registered outputs
   wire rd_go = exec & uses_file & (phase_r == PH_DECODE); // RQ12
   wire addr_go = exec & (phase_r == PH_DECODE);
   wire wr_go = exec & is_bset & (phase_r == PH_PROC); // RQ12
   wire tgt_go = exec & is_jump & (phase_r == PH_READ); // RQ3
   wire ld_go = exec & is_jump & (phase_r == PH_PROC); // RQ4

   assign bit_bus.data = data_r;
   assign bit_bus.bit_idx = bit_idx;
   assign bit_bus.skip_on_set = is_sks;

   // sequencing of execute and idle cycles
   always_comb
   begin
      state_nxt = state_r;
      two_word_nxt = two_word_r;
      if (cycle_end)
      begin
         unique case (state_r)
            ST_EXEC:
            begin
               if (is_jump)
               begin
                  state_nxt = ST_IDLE; // RQ4
                  two_word_nxt = 1'b0;
               end
               else if (skip_taken)
               begin
                  state_nxt = ST_IDLE; // RQ10
                  two_word_nxt = i_next_two_word; // RQ11
               end
            end
            ST_IDLE:
            begin
               state_nxt = two_word_r ? ST_IDLE2 : ST_EXEC; // RQ11
               two_word_nxt = 1'b0;
            end
            ST_IDLE2:
               state_nxt = ST_EXEC;
         endcase
      end
   end

   // a new word is taken only when the next cycle executes
   assign o_instr_take = cycle_end & (state_nxt == ST_EXEC);
   wire [15:0] instr_nxt = o_instr_take ? i_instr : RST_INSTR;

   // free-running phase counter, one turn per instruction cycle
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         phase_r <= RST_PHASE;
      else
         phase_r <= phase_r + 2'h1;
   end

   // execute or idle state; a two-word skip holds one extra idle
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_r <= ST_EXEC;
         two_word_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         two_word_r <= two_word_nxt;
      end
   end

   // instruction register; an idle cycle runs the empty word
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         instr_r <= RST_INSTR;
      else if (cycle_end)
         instr_r <= instr_nxt; // RQ10
   end

   // file register read in the second phase, sampled at its end
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rd_r <= 1'b0;
         addr_r <= '0;
         data_r <= 8'h00;
      end
      else
      begin
         rd_r <= rd_go; // RQ12
         if (addr_go)
            addr_r <= {bank, faddr}; // RQ7
         if (rd_r)
            data_r <= i_mem_rdata;
      end
   end

   // write back in the fourth phase; bit tests never write
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         wr_r <= 1'b0;
         wdata_r <= 8'h00;
      end
      else
      begin
         wr_r <= wr_go; // RQ12
         if (wr_go)
            wdata_r <= bit_bus.set_data; // RQ6
      end
   end

   // jump target is captured once the offset has been read
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         target_r <= '0;
      else if (tgt_go)
         target_r <= jump_dest; // RQ3
   end

   // program counter write lands in the last phase of the jump cycle
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         pc_load_r <= 1'b0;
      else
         pc_load_r <= ld_go; // RQ4
   end

   // no status flag is touched by any of these operations
   assign o_phase = phase_r;
   assign o_flush = ~exec; // RQ10
   assign o_pc_load = pc_load_r;
   assign o_pc_target = target_r;
   assign o_mem_rd = rd_r;
   assign o_mem_wr = wr_r;
   assign o_mem_addr = addr_r;
   assign o_mem_wdata = wdata_r;
endmodule

// >>> tb/bbx_exec_asserts.sv
`timescale 1ns/100ps
// port-level timing checks for the execute block
module bbx_exec_asserts
   import bbx_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [15:0] i_instr,
   input wire logic [1:0] o_phase,
   input wire logic o_instr_take,
   input wire logic o_flush,
   input wire logic o_pc_load,
   input wire logic o_mem_rd,
   input wire logic o_mem_wr
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // words taken this edge, by opcode
   wire jmp = o_instr_take && i_instr[15:11] == OP_REL_JUMP;
   wire set = o_instr_take && i_instr[15:12] == OP_BIT_SET;
   phase_wrap_a: assert property (o_phase == 2'h3 |=> o_phase == 2'h0)
      else $error("phase did not wrap");
   take_ph3_a: assert property (o_instr_take |-> o_phase == 2'h3)
      else $error("take outside phase 3");
   jump_load_a: assert property (jmp |-> ##4 o_pc_load)
      else $error("jump did not load pc");
   jump_idle_a: assert property (o_pc_load |=> o_flush [*4])
      else $error("no idle cycle after jump");
   load_refuse_a: assert property (o_pc_load |-> !o_instr_take)
      else $error("prefetch taken at jump");
   set_rdwr_a: assert property (set |-> ##2 o_mem_rd ##2 o_mem_wr)
      else $error("bit set access order");
   wr_ph3_a: assert property (
      o_mem_wr |-> o_phase == 2'h3 && $past(o_mem_rd, 2))
      else $error("write not after read");
   idle_quiet_a: assert property (
      o_flush |-> !o_mem_rd && !o_mem_wr && !o_pc_load)
      else $error("activity in idle cycle");
   cover property (o_pc_load);
   cover property (o_mem_wr);
   cover property (o_flush [*8]);
endmodule
bind bbx_exec bbx_exec_asserts chk_i (.i_clk(i_clk), .i_rst(i_rst),
   .i_instr(i_instr), .o_phase(o_phase), .o_instr_take(o_instr_take),
   .o_flush(o_flush), .o_pc_load(o_pc_load), .o_mem_rd(o_mem_rd),
   .o_mem_wr(o_mem_wr));

// >>> tb/bbx_exec_bench.sv
`timescale 1ns/100ps
module bbx_exec_bench;
   import bbx_pkg::*;
   logic clk = 0, rst = 1, two = 0;
   logic [15:0] ins = 16'hFFFF;
   logic [PC_W-1:0] pc = 21'h001000;
   logic [7:0] rdat = 8'h00;
   logic [BANK_W-1:0] bank_select_reg = 4'h5;
   wire [1:0] ph;
   wire tk, fl, ld, rd, wr;
   wire [PC_W-1:0] tg;
   wire [DADDR_W-1:0] ad;
   wire [7:0] wd;
   int bad_count = 0, cmp_count = 0, cyc, nfl, nwr;
   logic [PC_W-1:0] tg_s;
   logic [DADDR_W-1:0] ad_s;
   logic [7:0] wd_s;
   bbx_exec dut (.i_clk(clk), .i_rst(rst), .i_instr(ins),
      .i_next_two_word(two), .i_pc(pc), .i_bank_sel(bank_select_reg),
      .i_mem_rdata(rdat), .o_phase(ph), .o_instr_take(tk), .o_flush(fl),
      .o_pc_load(ld), .o_pc_target(tg), .o_mem_rd(rd), .o_mem_wr(wr),
      .o_mem_addr(ad), .o_mem_wdata(wd));
   // 40 MHz core clock
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e)
      begin
         bad_count++;
         $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
   endtask
   // hand one word over, then log the bus until the next take
   task automatic run(input logic [15:0] w, input logic [7:0] d,
                      input logic t);
      int n;
      n = 0;
      @(posedge clk);
      ins <= w;
      rdat <= d;
      two <= t;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (tk !== 1'b1 && n < 40);
      chk("take", tk, 1'b1);
      @(posedge clk);
      ins <= 16'hFFFF;
      cyc = 0;
      nfl = 0;
      nwr = 0;
      wd_s = 'x;
      tg_s = 'x;
      ad_s = 'x;
      do
      begin
         @(negedge clk);
         cyc++;
         nfl += fl;
         nwr += wr;
         if (wr) wd_s = wd;
         if (ld) tg_s = tg;
         if (rd) ad_s = ad;
      end
      while (tk !== 1'b1 && cyc < 20);
   endtask
   // extreme offsets both ways
   task automatic t_jump();
      run(16'hD3FF, 8'h00, 1'b0);
      chk("jump fwd", tg_s, pc + 21'h0007FE);
      chk("jump cyc", cyc, 8);
      chk("jump idle", nfl, 4);
      run(16'hD400, 8'h00, 1'b0);
      chk("jump back", tg_s, pc - 21'h000800);
   endtask
   // every bit index, both bank selectors, high and low access half
   task automatic t_set();
      for (int b = 0; b < 8; b++)
      begin
         run({4'h8, b[2:0], b[0], 8'h90}, 8'h00, 1'b0);
         chk("set data", wd_s, 8'h01 << b);
         chk("set addr", ad_s, b[0] ? 12'h590 : 12'hF90);
         chk("set cyc", cyc, 4);
      end
      run(16'h8E12, 8'h0A, 1'b0);
      chk("set keep", wd_s, 8'h8A);
      chk("set low", ad_s, 12'h012);
   endtask
   // both tests with bit 3 clear and set, others inverted
   task automatic t_skip();
      @(posedge clk);
      bank_select_reg <= 4'h3;
      for (int k = 0; k < 4; k++)
      begin
         run({k[1] ? 4'hB : 4'hA, 4'h7, 8'h44}, k[0] ? 8'h08 : 8'hF7, 1'b0);
         chk("skip cyc", cyc, (k[1] ^ k[0]) ? 8 : 4);
         chk("skip idle", nfl, (k[1] ^ k[0]) ? 4 : 0);
         chk("skip wr", nwr, 0);
         chk("skip addr", ad_s, 12'h344);
      end
      run(16'hB744, 8'h00, 1'b1);
      chk("skip two", cyc, 12);
   endtask
   task automatic report_and_stop();
      if (bad_count == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // main sequence after a 16-cycle reset
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_jump();
      t_set();
      t_skip();
      report_and_stop();
   end
   // hang guard of 2000 cycles, far beyond the fewer than 200 cycles needed
   initial
   begin
      #(25 * 2000);
      bad_count++;
      report_and_stop();
   end
endmodule
